// [spr_top.sv]
// SPI port registers, pin control and byte engine behind AXI4-Lite
// What this block does
// - A slave always uses select_in_n as input, never general-purpose I/O.
// - Deselected slave floats MISO and ignores serial clock edges mid-byte.
// - With spi_on low, select_in_n stays general-purpose and is ignored.
// - Master: select_in_n is GPIO without fault detect, input-only with it.
// - rx_irq_enable, reset low, gates the receive-full interrupt request.
// - master_select picks master at 1, slave at 0; reset sets it.
// - CPOL, reset low, sets the serial clock idle level.
// - CPHA selects clock/data phase; reset sets it.
// - wired_or_mode makes clock and data pins open-drain, pullups off.
// - spi_on, reset low, enables the port; clearing it partially resets.
// - Partial reset sets tx empty, aborts, clears shifter, keeps flags.
// - tx_irq_enable, reset low, gates the transmit-empty interrupt request.
// - rx_full_flag sets on byte receipt, clears by status then data read.
// - error_irq_enable lets mode fault and overrun raise requests.
// - Byte arriving while full sets overrun, keeps old byte, drops new.
// - Mode fault: slave select rises mid-byte, or master select goes low.
// - Mode fault clears by status read then control write only.
// - tx_empty_flag sets on hand-over, clears on data write, reset sets.
// - rate_select gives divisor 2, 8, 32 or 128 in master mode only.
// - Master serial clock equals base clock over twice the divisor.
// - Data writes go to transmit buffer, reads come from receive buffer.
`timescale 1ns/1ps
module spr_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [spr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [spr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic select_in_n,
  output logic ss_gpio,
  output logic pullup_en,
  // Interrupt requests
  output logic rx_irq_req,
  output logic tx_irq_req,
  output logic err_irq_req
);
  import spr_pkg::*;

  spr_ctrl_s ctrl;
  logic error_irq_enable;
  logic fault_detect_enable;
  logic [1:0] rate_select;
  logic rx_full_flag;
  logic overrun_flag;
  logic mode_fault_flag;
  logic tx_empty_flag;
  logic rx_arm;
  logic ovr_arm;
  logic mode_fault_flag_arm;
  logic [7:0] tx_buf;
  logic [7:0] rx_data;
  logic [7:0] shreg;
  logic samp;
  logic out_q;
  logic sclk_q;
  logic [3:0] edge_cnt;
  spr_state_e state;
  spr_pins_s pin_s;
  logic sclk_d;
  logic ss_d;
  logic tick;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_en;
  logic [7:0] stat;
  logic [31:0] rd_word;

  spr_sync #(.W(PIN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({sclk_i, mosi_i, miso_i, select_in_n}),
    .q(pin_s)
  );

  // Bus decode
  wire wr_go = aw_hold && w_hold && !bvalid;
  wire wr_ctrl = wr_go && w_en && aw_addr == A_CTRL;
  wire wr_stat = wr_go && w_en && aw_addr == A_STAT;
  wire wr_data = wr_go && w_en && aw_addr == A_DATA;
  wire wr_map = aw_addr == A_CTRL || aw_addr == A_STAT || aw_addr == A_DATA;
  wire rd_go = arvalid && arready;
  wire rd_stat = rd_go && araddr == A_STAT;
  wire rd_data = rd_go && araddr == A_DATA;

  // Mode and event decode
  wire master_on = ctrl.spi_on && ctrl.master_select;
  wire slave_sel = ctrl.spi_on && !ctrl.master_select && !pin_s.ss_n;
  wire mf_master = master_on && fault_detect_enable && !pin_s.ss_n;
  wire mf_slave = ctrl.spi_on && !ctrl.master_select && fault_detect_enable
    && pin_s.ss_n && !ss_d && edge_cnt != 4'h0;
  wire slv_evt = slave_sel && pin_s.sclk != sclk_d;
  wire evt = master_on ? tick : slv_evt;
  wire leading = !edge_cnt[0];
  wire in_bit = master_on ? pin_s.miso : pin_s.mosi;
  wire load = state == SPR_IDLE && !tx_empty_flag && !wr_data
    && (master_on || slave_sel);
  wire active = master_on || slave_sel;
  wire done = state == SPR_RUN && active && evt && edge_cnt == EDGE_LAST;
  wire [7:0] rx_byte = ctrl.cpha ? {shreg[6:0], in_bit} : {shreg[6:0], samp};
  wire clr_rx = rx_arm && rd_data;
  wire take = done && (!rx_full_flag || clr_rx);

  spr_baud u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(master_on && state == SPR_RUN),
    .rate_select(rate_select),
    .tick(tick)
  );

  assign stat[ST_RXF] = rx_full_flag;
  assign stat[ST_ERROR_IRQ_ENABLE] = error_irq_enable;
  assign stat[ST_OVR] = overrun_flag;
  assign stat[ST_MODE_FAULT_FLAG] = mode_fault_flag;
  assign stat[ST_TXE] = tx_empty_flag;
  assign stat[ST_FDEN] = fault_detect_enable;
  assign stat[ST_RATE_HI] = rate_select[1];
  assign stat[ST_RATE_LO] = rate_select[0];

  always_comb begin
    case (araddr)
      A_CTRL: rd_word = {24'h000000, ctrl};
      A_STAT: rd_word = {24'h000000, stat};
      A_DATA: rd_word = {24'h000000, rx_data};
      default: rd_word = 32'h00000000;
    endcase
  end

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
      aw_addr <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      awready <= 1'b0;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      aw_hold <= 1'b0;
      awready <= 1'b1;
    end
  end

  // Write data channel, only the low byte lane carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
      w_byte <= 8'h00;
      w_en <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold <= 1'b1;
      wready <= 1'b0;
      w_byte <= wdata[7:0];
      w_en <= wstrb[0];
    end else if (wr_go) begin
      w_hold <= 1'b0;
      wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= (rd_word == 32'h00000000 && araddr != A_CTRL && araddr != A_STAT
        && araddr != A_DATA) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Control register; a master mode fault drops the port out of master
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= spr_ctrl_s'(w_byte & CTRL_WMASK);
      end
      if (mf_master) begin
        ctrl.spi_on <= 1'b0;
        ctrl.master_select <= 1'b0;
      end
    end
  end

  // Writable part of the status and control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_irq_enable <= 1'b0;
      fault_detect_enable <= 1'b0;
      rate_select <= 2'h0;
    end else if (wr_stat) begin
      error_irq_enable <= w_byte[ST_ERROR_IRQ_ENABLE];
      fault_detect_enable <= w_byte[ST_FDEN];
      rate_select <= {w_byte[ST_RATE_HI], w_byte[ST_RATE_LO]};
    end
  end

  // Receive flags and buffer; a new byte wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_flag <= 1'b0;
      rx_arm <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (take) begin
        rx_full_flag <= 1'b1;
        rx_data <= rx_byte;
      end else if (clr_rx) begin
        rx_full_flag <= 1'b0;
      end
      if (rd_stat && rx_full_flag) begin
        rx_arm <= 1'b1;
      end else if (clr_rx || !rx_full_flag) begin
        rx_arm <= 1'b0;
      end
    end
  end

  // Overrun keeps the older byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_flag <= 1'b0;
      ovr_arm <= 1'b0;
    end else begin
      if (done && !take) begin
        overrun_flag <= 1'b1;
      end else if (ovr_arm && rd_data) begin
        overrun_flag <= 1'b0;
      end
      if (rd_stat && overrun_flag) begin
        ovr_arm <= 1'b1;
      end else if (rd_data || !overrun_flag) begin
        ovr_arm <= 1'b0;
      end
    end
  end

  // Mode fault, cleared by status read then control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_fault_flag <= 1'b0;
      mode_fault_flag_arm <= 1'b0;
      ss_d <= 1'b1;
    end else begin
      ss_d <= pin_s.ss_n;
      if (mf_master || mf_slave) begin
        mode_fault_flag <= 1'b1;
      end else if (mode_fault_flag_arm && wr_ctrl) begin
        mode_fault_flag <= 1'b0;
      end
      if (rd_stat && mode_fault_flag) begin
        mode_fault_flag_arm <= 1'b1;
      end else if (wr_ctrl || !mode_fault_flag) begin
        mode_fault_flag_arm <= 1'b0;
      end
    end
  end

  // Transmit buffer and empty flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_empty_flag <= 1'b1;
      tx_buf <= 8'h00;
    end else begin
      if (wr_data) begin
        tx_buf <= w_byte;
      end
      if (!ctrl.spi_on || load) begin
        tx_empty_flag <= 1'b1;
      end else if (wr_data) begin
        tx_empty_flag <= 1'b0;
      end
    end
  end

  // Byte engine; disabled port or lost select aborts the byte
  always_ff @(posedge aclk) begin
    sclk_d <= pin_s.sclk;
    if (!aresetn || !ctrl.spi_on) begin
      state <= SPR_IDLE;
      edge_cnt <= 4'h0;
      shreg <= 8'h00;
      samp <= 1'b0;
      out_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      case (state)
        SPR_IDLE: begin
          sclk_q <= ctrl.cpol;
          edge_cnt <= 4'h0;
          if (load) begin
            shreg <= tx_buf;
            out_q <= tx_buf[7];
          end
          if (master_on ? load : slave_sel) begin
            state <= SPR_RUN;
          end
        end
        SPR_RUN: begin
          if (!active) begin
            state <= SPR_IDLE;
            edge_cnt <= 4'h0;
          end else if (evt) begin
            edge_cnt <= edge_cnt + 4'h1;
            if (master_on) begin
              sclk_q <= ~sclk_q;
            end
            if (leading) begin
              if (!ctrl.cpha) begin
                samp <= in_bit;
              end else begin
                out_q <= shreg[7];
              end
            end else begin
              shreg <= rx_byte;
              if (!ctrl.cpha) begin
                out_q <= shreg[6];
              end
            end
            if (edge_cnt == EDGE_LAST) begin
              state <= SPR_IDLE;
            end
          end
        end
        default: state <= SPR_IDLE;
      endcase
    end
  end

  // Pin drivers; open-drain only ever drives low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      pullup_en <= 1'b1;
      ss_gpio <= 1'b1;
    end else begin
      sclk_o <= sclk_q && !ctrl.wired_or_mode;
      sclk_oe <= master_on && (!ctrl.wired_or_mode || !sclk_q);
      mosi_o <= out_q && !ctrl.wired_or_mode;
      mosi_oe <= master_on && (!ctrl.wired_or_mode || !out_q);
      miso_o <= out_q && !ctrl.wired_or_mode;
      miso_oe <= slave_sel && (!ctrl.wired_or_mode || !out_q);
      pullup_en <= !ctrl.wired_or_mode;
      ss_gpio <= !ctrl.spi_on || (ctrl.master_select && !fault_detect_enable);
    end
  end

  // Interrupt requests
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
      err_irq_req <= 1'b0;
    end else begin
      rx_irq_req <= rx_full_flag && ctrl.rx_irq_enable;
      tx_irq_req <= tx_empty_flag && ctrl.tx_irq_enable && ctrl.spi_on;
      err_irq_req <= error_irq_enable && (mode_fault_flag || overrun_flag);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_desel_float;
    !ctrl.master_select && pin_s.ss_n |=> !miso_oe;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("MISO driven while deselected");

  property p_gpio_off;
    !ctrl.spi_on |=> ss_gpio;
  endproperty
  a_gpio_off: assert property (p_gpio_off) else $error("select not GPIO while off");

  property p_master_sel;
    ctrl.spi_on && !ctrl.master_select |=> !ss_gpio;
  endproperty
  a_master_sel: assert property (p_master_sel) else $error("slave select used as GPIO");

  property p_fden_gpio;
    master_on ##1 master_on |-> ss_gpio == !$past(fault_detect_enable);
  endproperty
  a_fden_gpio: assert property (p_fden_gpio) else $error("master select ownership wrong");

  property p_rx_irq;
    rx_full_flag && ctrl.rx_irq_enable |=> rx_irq_req;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");

  property p_idle_clk;
    master_on && state == SPR_IDLE && !load ##1 master_on |-> sclk_q == $past(ctrl.cpol);
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock level wrong");

  property p_partial;
    !ctrl.spi_on |=> tx_empty_flag && state == SPR_IDLE && edge_cnt == 4'h0;
  endproperty
  a_partial: assert property (p_partial) else $error("partial reset incomplete");

  property p_overrun;
    done && rx_full_flag && !clr_rx |=> overrun_flag && rx_data == $past(rx_data);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost old byte");

  property p_mode_fault_flag_hold;
    mode_fault_flag && !wr_ctrl |=> mode_fault_flag;
  endproperty
  a_mode_fault_flag_hold: assert property (p_mode_fault_flag_hold) else $error("mode fault cleared early");

  property p_rate2;
    tick && master_on && rate_select == 2'h0 && state == SPR_RUN && edge_cnt < 4'he
      |=> !tick ##1 tick;
  endproperty
  a_rate2: assert property (p_rate2) else $error("divisor 2 edge spacing wrong");

  property p_tx_write;
    wr_data && ctrl.spi_on |=> !tx_empty_flag && tx_buf == $past(w_byte);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("data write not taken");
endmodule // spr_top

// [spr_pkg.sv]
// Shared constants and types for the SPI pin and register block
package spr_pkg;
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status and control register bit positions
  localparam int ST_RXF = 7;
  localparam int ST_ERROR_IRQ_ENABLE = 6;
  localparam int ST_OVR = 5;
  localparam int ST_MODE_FAULT_FLAG = 4;
  localparam int ST_TXE = 3;
  localparam int ST_FDEN = 2;
  localparam int ST_RATE_HI = 1;
  localparam int ST_RATE_LO = 0;
  // Control register layout
  typedef struct packed {
    logic rx_irq_enable;
    logic rsvd;
    logic master_select;
    logic cpol;
    logic cpha;
    logic wired_or_mode;
    logic spi_on;
    logic tx_irq_enable;
  } spr_ctrl_s;
  localparam spr_ctrl_s CTRL_RST = 8'h28;
  localparam logic [7:0] CTRL_WMASK = 8'hbf;
  // Synchronised pin levels
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } spr_pins_s;
  localparam int PIN_W = 4;
  // Half period of the serial clock in module clocks, one per divisor
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] BD_00 = 8'h02;
  localparam logic [DIV_W-1:0] BD_01 = 8'h08;
  localparam logic [DIV_W-1:0] BD_10 = 8'h20;
  localparam logic [DIV_W-1:0] BD_11 = 8'h80;
  // Sixteen clock edges make one byte
  localparam logic [3:0] EDGE_LAST = 4'hf;
  typedef enum logic [0:0] {
    SPR_IDLE = 1'b0,
    SPR_RUN = 1'b1
  } spr_state_e;
endpackage

// [spr_sync.sv]
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module spr_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // spr_sync

// [spr_baud.sv]
// Master serial clock edge generator
`timescale 1ns/1ps
module spr_baud (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic [1:0] rate_select,
  // One pulse per serial clock edge
  output logic tick
);
  import spr_pkg::*;

  logic [spr_pkg::DIV_W-1:0] cnt;
  logic [spr_pkg::DIV_W-1:0] lim;

  always_comb begin
    case (rate_select)
      2'h0: lim = BD_00 - 8'h01;
      2'h1: lim = BD_01 - 8'h01;
      2'h2: lim = BD_10 - 8'h01;
      default: lim = BD_11 - 8'h01;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == lim) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // spr_baud

// [spr_peer.sv]
// Far-side SPI device: slave answering the port as master, or master driving it as slave
`timescale 1ns/1ps
module spr_peer (
  // Clock
  input wire logic aclk,
  // Pins of the port
  input wire logic dut_sclk,
  input wire logic dut_sclk_oe,
  input wire logic dut_miso,
  input wire logic dut_miso_oe,
  input wire logic dut_mosi,
  // Bench control
  input wire logic sel_n,
  input wire logic fill,
  input wire logic [4:0] n_edges,
  input wire logic go,
  // Line levels and status
  output logic sclk_line,
  output logic miso_line,
  output logic busy,
  output logic [7:0] got
);
  logic peer_sclk = 1'h0;
  logic last_miso = 1'h0;
  logic [4:0] left = 5'h0;
  logic [2:0] div = 3'h0;
  assign busy = (left != 5'h0);
  // Own clock idles low and toggles every six cycles, same polarity as the port
  always_ff @(posedge aclk) begin
    if (go && left == 5'h0) begin
      left <= n_edges;
      div <= 3'h0;
    end else if (left != 5'h0) begin
      div <= div + 3'h1;
      if (div == 3'h5) begin
        div <= 3'h0;
        peer_sclk <= ~peer_sclk;
        left <= left - 5'h1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    last_miso <= miso_line;
  end
  logic sclk_prev = 1'h0;
  // Bits the port sends, taken on the falling clock: MOSI as master, MISO as slave
  always_ff @(posedge aclk) begin
    sclk_prev <= sclk_line;
    if (sclk_prev && !sclk_line) begin
      got <= {got[6:0], dut_sclk_oe ? dut_mosi : miso_line};
    end
  end
  assign sclk_line = dut_sclk_oe ? dut_sclk : peer_sclk;
  // A released line flips every cycle while sel_n is high, so no stale level can pass for data
  assign miso_line = dut_miso_oe ? dut_miso : (!sel_n ? fill : ~last_miso);
endmodule // spr_peer

// [spr_top_tb.sv]
// Self-checking bench for the SPI pin and register block
`timescale 1ns/1ps
module spr_top_tb;
  import spr_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic mosi_i = 1'h0;
  logic select_in_n = 1'h1;
  logic sel_n = 1'h1;
  logic fill = 1'h0;
  logic go = 1'h0;
  logic [4:0] n_edges = 5'h0;
  logic awready, wready, bvalid, arready, rvalid, busy, sclk_line, miso_line;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_gpio, pullup_en;
  logic rx_irq_req, tx_irq_req, err_irq_req;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata;
  logic [7:0] got;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #25 aclk = ~aclk;
  spr_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk_i(sclk_line),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_line), .miso_o(miso_o), .miso_oe(miso_oe), .select_in_n(select_in_n),
    .ss_gpio(ss_gpio), .pullup_en(pullup_en), .rx_irq_req(rx_irq_req),
    .tx_irq_req(tx_irq_req), .err_irq_req(err_irq_req)
  );
  spr_peer peer_u (
    .aclk(aclk), .dut_sclk(sclk_o), .dut_sclk_oe(sclk_oe), .dut_miso(miso_o),
    .dut_miso_oe(miso_oe), .dut_mosi(mosi_o), .sel_n(sel_n), .fill(fill),
    .n_edges(n_edges), .go(go), .sclk_line(sclk_line), .miso_line(miso_line),
    .busy(busy), .got(got)
  );
  task automatic stop_test;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
    // Registered outputs launched by the write settle one edge later
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rsp = rresp;
    rready <= 1'h0;
    chk(what, rdata, {24'h0, exp});
    @(posedge aclk);
  endtask
  task automatic run_peer(input logic [4:0] n);
    @(posedge aclk);
    n_edges <= n;
    go <= 1'h1;
    @(posedge aclk);
    go <= 1'h0;
    do @(posedge aclk); while (busy === 1'h1);
  endtask
  task automatic half_period(input int bd);
    logic s;
    int n;
    s = sclk_o;
    while (sclk_o === s) @(posedge aclk);
    s = sclk_o;
    n = 0;
    while (sclk_o === s) begin
      @(posedge aclk);
      n++;
    end
    chk("half period", n, bd);
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rc(A_CTRL, 8'h28, "control reset");
    rc(A_STAT, 8'h08, "status reset");
    chk("select free", ss_gpio, 1'h1);
    chk("pullups", pullup_en, 1'h1);
    chk("irq idle", {rx_irq_req, tx_irq_req, err_irq_req}, 3'h0);
    wr(8'h0c, 8'h55);
    chk("unmapped write", rsp, RESP_SLVERR);
    rc(8'h0c, 8'h00, "unmapped read");
    chk("unmapped read resp", rsp, RESP_SLVERR);
    // Master byte at every rate; the peer returns all ones or all zeros
    sel_n <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      fill <= r[0];
      wr(A_STAT, r[7:0]);
      wr(A_CTRL, 8'hab);
      chk("tx irq", tx_irq_req, 1'h1);
      chk("select free in master", ss_gpio, 1'h1);
      chk("mosi driven", mosi_oe, 1'h1);
      wr(A_DATA, 8'ha5);
      half_period(2 << (2 * r));
      while (rx_irq_req !== 1'h1) @(posedge aclk);
      rc(A_STAT, 8'h88 | r[7:0], "status full");
      rc(A_DATA, r[0] ? 8'hff : 8'h00, "rx byte");
      chk("rx irq cleared", rx_irq_req, 1'h0);
      chk("mosi byte", got, 8'ha5);
    end
    // Second byte before the first is read
    fill <= 1'h1;
    wr(A_STAT, 8'h40);
    wr(A_DATA, 8'h3c);
    while (rx_irq_req !== 1'h1) @(posedge aclk);
    fill <= 1'h0;
    wr(A_DATA, 8'hc3);
    while (err_irq_req !== 1'h1) @(posedge aclk);
    rc(A_STAT, 8'he8, "overrun status");
    chk("mosi second", got, 8'hc3);
    rc(A_DATA, 8'hff, "older byte kept");
    rc(A_STAT, 8'h48, "flags cleared");
    // Master mode fault
    wr(A_STAT, 8'h04);
    chk("select owned", ss_gpio, 1'h0);
    select_in_n <= 1'h0;
    repeat (4) @(posedge aclk);
    select_in_n <= 1'h1;
    rc(A_STAT, 8'h1c, "master fault");
    rc(A_CTRL, 8'h89, "fault disables");
    wr(A_STAT, 8'h00);
    rc(A_STAT, 8'h18, "fault kept");
    wr(A_CTRL, 8'h08);
    rc(A_STAT, 8'h08, "fault cleared");
    chk("select free when off", ss_gpio, 1'h1);
    // Abort a slow transfer by switching off
    wr(A_STAT, 8'h03);
    wr(A_CTRL, 8'h2a);
    wr(A_DATA, 8'h81);
    repeat (300) @(posedge aclk);
    wr(A_CTRL, 8'h28);
    chk("clock released", sclk_oe, 1'h0);
    rc(A_STAT, 8'h0b, "partial reset");
    wr(A_CTRL, 8'h3a);
    repeat (4) @(posedge aclk);
    chk("idle level", sclk_o, 1'h1);
    wr(A_CTRL, 8'h2e);
    chk("pullups off", pullup_en, 1'h0);
    // Slave role, the peer drives the clock
    sel_n <= 1'h1;
    mosi_i <= 1'h1;
    wr(A_STAT, 8'h04);
    wr(A_CTRL, 8'h0a);
    chk("slave select owned", ss_gpio, 1'h0);
    wr(A_DATA, 8'h5a);
    select_in_n <= 1'h0;
    run_peer(5'h10);
    repeat (6) @(posedge aclk);
    chk("slave drives", miso_oe, 1'h1);
    rc(A_STAT, 8'h8c, "slave full");
    rc(A_DATA, 8'hff, "slave byte");
    chk("slave sent", got, 8'h5a);
    select_in_n <= 1'h1;
    run_peer(5'h10);
    repeat (6) @(posedge aclk);
    chk("slave floats", miso_oe, 1'h0);
    rc(A_STAT, 8'h0c, "clocks ignored");
    select_in_n <= 1'h0;
    run_peer(5'h06);
    select_in_n <= 1'h1;
    repeat (6) @(posedge aclk);
    rc(A_STAT, 8'h1c, "slave fault");
    stop_test();
  end
endmodule // spr_top_tb
